// file: cglp_ctrl.sv
// Clock gear, oscillator select and low-power mode sequencer with AHB-Lite registers.
// Assumes the core reports wait-for-interrupt as a pulse and wake sources are synchronous.
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module cglp_ctrl
	import cglp_pkg::*;
#(
	parameter int NPERIPH = CGLP_NPERIPH,
	parameter int NIRQ    = 8
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [7:0]          haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic [31:0]              hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire logic                wait_req,
	input  wire logic [CGLP_NWAKE-1:0] ext_wake_irq,
	input  wire logic [NIRQ-1:0]     idle_wake_irq,
	input  wire logic                watchdog_nmi,
	input  wire logic                systick_irq,
	input  wire logic                int_osc_tick,
	input  wire logic                ext_osc_tick,
	output cglp_clk_t                clk_ctl,
	output cglp_pin_t                pin_ctl,
	output logic [1:0]               mode_state
);
	if (NPERIPH != CGLP_NPERIPH || NIRQ < 1) begin : g_param_check
		$error("cglp_ctrl: unsupported parameters");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                    wr_pend;
		logic [7:0]              addr;
		logic [31:0]             rdata;
		logic                    wu_start;
		logic                    wu_sel_ext;
		logic [11:0]             wup_count;
		logic                    hosc_on;
		logic                    ext_osc_enable;
		logic                    int_osc_enable;
		logic                    hs_source_select;
		logic                    pll_on;
		logic [2:0]              gear_req;
		logic [2:0]              gear_act;
		logic [3:0]              gear_dly;
		logic [2:0]              prescaler_divide_select;
		logic                    periph_clock_select;
		logic [NPERIPH-1:0]      idle_en;
		logic [2:0]              stby;
		logic                    drve;
		logic [CGLP_NWAKE-1:0]   wake_en;
		cglp_mode_t              mode;
		cglp_clk_t               clk;
		cglp_pin_t               pin;
	} cglp_state_t;

	cglp_state_t st_reg;
	cglp_state_t st_next;
	logic        wu_busy;
	logic        stop_wake;
	logic        idle_wake;
	logic [31:0] osc_rd;
	logic [31:0] sys_rd;

	cglp_warmup #(
		.CNT_W (16)
	) u_warmup (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.start       (st_reg.wu_start),
		.use_ext     (st_reg.wu_sel_ext), // RL2
		.int_tick    (int_osc_tick),
		.ext_tick    (ext_osc_tick),
		.count_value (st_reg.wup_count),
		.busy        (wu_busy)
	);

	// ****************************************
	// Wake decode
	// ****************************************
	always_comb begin
		stop_wake = |(ext_wake_irq & st_reg.wake_en); // RL19 RL21 RL25
		idle_wake = (|ext_wake_irq) | (|idle_wake_irq) | watchdog_nmi | systick_irq; // RL19
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.wu_start = 1'b0;
		st_next.wr_pend = 1'b0;
		st_next.rdata = '0;

		// Address phase capture; every transfer completes with no wait
		if (hsel && hready && htrans[1]) begin
			st_next.addr = haddr;
			st_next.wr_pend = hwrite;
		end

		// Gear settles after a short delay; an in-range gear write below reloads the count
		if (st_reg.gear_dly != 4'h0) begin
			st_next.gear_dly = st_reg.gear_dly - 4'h1;
			if (st_reg.gear_dly == 4'h1) begin
				st_next.gear_act = st_reg.gear_req; // RL5
			end
		end

		if (st_reg.wr_pend) begin
			unique case (st_reg.addr)
				CGLP_OSC_OFF: begin
					// Starting while the counter runs would restart it mid-count
					st_next.wu_start = hwdata[CGLP_WUEON_BIT] && !wu_busy; // RL1
					st_next.pll_on = hwdata[CGLP_PLL_BIT];
					// Takeover is one way until reset; osc_pin_takeover then stays high
					st_next.hosc_on = st_reg.hosc_on | hwdata[CGLP_HOSC_BIT]; // RL7
					st_next.ext_osc_enable = hwdata[CGLP_EXT_EN_BIT];
					st_next.wu_sel_ext = hwdata[CGLP_WSEL2_BIT]; // RL2
					st_next.wup_count = hwdata[CGLP_WUP_LSB +: 12];
					// Select only moves to external once it runs and warm-up is done
					if (!hwdata[CGLP_SRC_SEL_BIT] || (st_reg.ext_osc_enable && !wu_busy)) begin
						st_next.hs_source_select = hwdata[CGLP_SRC_SEL_BIT]; // RL6
					end
					// Keep the internal oscillator on if it fed the system clock before this write
					st_next.int_osc_enable = hwdata[CGLP_INT_EN_BIT] |
						!st_reg.hs_source_select; // RL6
				end
				CGLP_SYS_OFF: begin
					if (hwdata[CGLP_GEAR_LSB +: 3] <= CGLP_GEAR_MAX) begin
						st_next.gear_req = hwdata[CGLP_GEAR_LSB +: 3]; // RL4
						st_next.gear_dly = CGLP_GEAR_DLY; // RL5
					end
					st_next.prescaler_divide_select = hwdata[CGLP_PRESC_LSB +: 3]; // RL8
					st_next.periph_clock_select = hwdata[CGLP_PER_SRC_BIT];
					st_next.idle_en = hwdata[CGLP_IDLEN_LSB +: NPERIPH];
				end
				CGLP_STBY_OFF: begin
					// Reserved codes are dropped rather than stored
					if (hwdata[2:0] == CGLP_MODE_STOP || hwdata[2:0] == CGLP_MODE_IDLE) begin
						st_next.stby = hwdata[2:0]; // RL17
					end
					st_next.drve = hwdata[CGLP_DRVE_BIT];
				end
				CGLP_WAKE_OFF: begin
					st_next.wake_en = hwdata[CGLP_NWAKE-1:0]; // RL25
				end
				default: begin
				end
			endcase
		end

		// Mode sequencer
		unique case (st_reg.mode)
			CGLP_NORMAL: begin
				if (wait_req && st_reg.stby == CGLP_MODE_IDLE) begin
					st_next.mode = CGLP_IDLE; // RL11
				end else if (wait_req && st_reg.stby == CGLP_MODE_STOP && !wu_busy) begin
					st_next.mode = CGLP_STOP; // RL11
				end
			end
			CGLP_IDLE: begin
				if (idle_wake) begin
					st_next.mode = CGLP_NORMAL; // RL19
				end
			end
			CGLP_STOP: begin
				if (stop_wake) begin
					st_next.mode = CGLP_WARM; // RL23 RL25
					st_next.wu_start = 1'b1; // RL23
				end
			end
			CGLP_WARM: begin
				if (!wu_busy && !st_reg.wu_start) begin
					st_next.mode = CGLP_NORMAL; // RL15 RL23
				end
			end
		endcase

		// Clock and pin outputs from the next mode and the register settings
		st_next.clk.core_clk_en = (st_next.mode == CGLP_NORMAL); // RL10 RL13
		for (int i = 0; i < NPERIPH; i++) begin
			st_next.clk.periph_clk_en[i] = (st_next.mode == CGLP_NORMAL) ||
				(st_next.mode == CGLP_IDLE && st_next.idle_en[i]); // RL13
		end
		// Oscillators keep running during warm-up so the count has a clock
		st_next.clk.int_osc_run = st_next.int_osc_enable && st_next.mode != CGLP_STOP; // RL15
		st_next.clk.ext_osc_run = st_next.ext_osc_enable && st_next.mode != CGLP_STOP; // RL15
		st_next.clk.pll_run = st_next.pll_on && st_next.mode != CGLP_STOP &&
			st_next.mode != CGLP_WARM; // RL15
		st_next.clk.sys_src_ext = st_next.hs_source_select;
		st_next.clk.gear_sel = st_next.gear_act; // RL4
		st_next.clk.prescale_sel = st_next.prescaler_divide_select; // RL8
		st_next.clk.periph_src_sel = st_next.periph_clock_select;
		st_next.pin.osc_pin_takeover = st_next.hosc_on; // RL7
		st_next.pin.gpio_io_en = st_next.mode != CGLP_STOP || st_next.drve; // RL16
		st_next.pin.x2_out = 1'b1; // RL16
		st_next.pin.x2_oe = st_next.hosc_on;
		st_next.pin.analog_keep = 1'b1; // RL18

		// Read data is decoded in the address phase so it stands through the data
		// phase; decoding the next state keeps a write landing now visible
		osc_rd = '0;
		osc_rd[CGLP_WUEF_BIT] = wu_busy | st_reg.wu_start | st_next.wu_start; // RL1
		osc_rd[CGLP_PLL_BIT] = st_next.pll_on;
		osc_rd[CGLP_HOSC_BIT] = st_next.hosc_on;
		osc_rd[CGLP_EXT_EN_BIT] = st_next.ext_osc_enable;
		osc_rd[CGLP_INT_EN_BIT] = st_next.int_osc_enable;
		osc_rd[CGLP_WSEL2_BIT] = st_next.wu_sel_ext;
		osc_rd[CGLP_SRC_SEL_BIT] = st_next.hs_source_select; // RL6
		osc_rd[CGLP_WUP_LSB +: 12] = st_next.wup_count;
		sys_rd = '0;
		sys_rd[CGLP_GEAR_LSB +: 3] = st_next.gear_req;
		sys_rd[CGLP_PRESC_LSB +: 3] = st_next.prescaler_divide_select;
		sys_rd[CGLP_PER_SRC_BIT] = st_next.periph_clock_select;
		sys_rd[CGLP_IDLEN_LSB +: NPERIPH] = st_next.idle_en;
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr)
				CGLP_OSC_OFF: begin
					st_next.rdata = osc_rd;
				end
				CGLP_SYS_OFF: begin
					st_next.rdata = sys_rd;
				end
				CGLP_STBY_OFF: begin
					st_next.rdata = {15'h0000, st_next.drve, 13'h0000, st_next.stby};
				end
				CGLP_WAKE_OFF: begin
					st_next.rdata = {29'h0000_0000, st_next.wake_en};
				end
				CGLP_STAT_OFF: begin
					st_next.rdata = {30'h0000_0000, st_next.mode};
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// A reset return skips auto warm-up; reset is held until stable
			st_reg <= '0; // RL22 RL24
			st_reg.int_osc_enable <= 1'b1; // RL3
			st_reg.stby <= CGLP_STBY_RST;
			st_reg.gear_req <= CGLP_GEAR_RST; // RL4
			st_reg.gear_act <= CGLP_GEAR_RST; // RL4
			st_reg.prescaler_divide_select <= CGLP_PRESC_RST; // RL8
			st_reg.wup_count <= CGLP_WUP_RST;
			st_reg.mode <= CGLP_NORMAL; // RL10
			st_reg.clk.core_clk_en <= 1'b1; // RL10
			st_reg.clk.periph_clk_en <= '1; // RL10
			st_reg.clk.int_osc_run <= 1'b1; // RL3
			st_reg.pin.gpio_io_en <= 1'b1;
			st_reg.pin.x2_out <= 1'b1;
			st_reg.pin.analog_keep <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hrdata = st_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign clk_ctl = st_reg.clk;
	assign pin_ctl = st_reg.pin;
	assign mode_state = st_reg.mode;
endmodule

// file: cglp_pkg.sv
// Constants, register map and state types for the clock gear and low-power controller.
// Assumes a single 100 MHz hclk domain and an AHB-Lite master reaching the registers.
// Rules from the document
// [RL1] Start bit runs warm-up; busy flag reads one
// [RL2] Source select picks external oscillator count clock
// [RL3] Reset: internal oscillator on, external off, selected
// [RL4] Gear divides by 1,2,4,8,16; resets undivided
// [RL5] Gear write applies after short delay
// [RL6] Switch to external only after warm-up, confirm select
// [RL7] Pin takeover hands port pins to oscillator
// [RL8] Prescaler clock divides peripheral clock; resets undivided
// [RL9] Software keeps prescaler slower, gear fixed running
// [RL10] Reset leaves device in NORMAL mode
// [RL11] Low power entered only on wait-for-interrupt
// [RL12] Software avoids wait-for-event and deep sleep
// [RL13] IDLE stops core; disabled peripherals hold
// [RL14] Software stops watchdog before IDLE
// [RL15] STOP halts all clocks; release returns prior mode
// [RL16] STOP pins follow drive bit; crystal output high
// [RL17] Mode codes: STOP 001, IDLE 011, rest reserved
// [RL18] Voltage detector and power-on reset stay on
// [RL19] STOP woken by external wakes; IDLE by more
// [RL20] Level wake sources hold until handling starts
// [RL21] STOP wake needs controller detect enable
// [RL22] Reset pin release gives NORMAL, registers initialised
// [RL23] STOP exit runs automatic warm-up before clock
// [RL24] Reset return starts no automatic warm-up
// [RL25] Per-source wake enables gate STOP warm-up
package cglp_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CGLP_OSC_OFF  = 8'h00;
	localparam logic [7:0] CGLP_SYS_OFF  = 8'h04;
	localparam logic [7:0] CGLP_STBY_OFF = 8'h08;
	localparam logic [7:0] CGLP_WAKE_OFF = 8'h0C;
	localparam logic [7:0] CGLP_STAT_OFF = 8'h10;
	// Oscillator control fields
	localparam int CGLP_WUEON_BIT   = 0;
	localparam int CGLP_WUEF_BIT    = 1;
	localparam int CGLP_PLL_BIT     = 2;
	localparam int CGLP_HOSC_BIT    = 8;
	localparam int CGLP_EXT_EN_BIT  = 9;
	localparam int CGLP_INT_EN_BIT  = 10;
	localparam int CGLP_WSEL2_BIT   = 15;
	localparam int CGLP_SRC_SEL_BIT = 17;
	localparam int CGLP_WUP_LSB     = 20;
	// System control fields
	localparam int CGLP_GEAR_LSB    = 0;
	localparam int CGLP_PRESC_LSB   = 8;
	localparam int CGLP_PER_SRC_BIT = 12;
	localparam int CGLP_IDLEN_LSB   = 16;
	// Standby fields
	localparam int CGLP_DRVE_BIT    = 16;
	// ****************************************
	// Encodings and reset values
	// ****************************************
	localparam logic [2:0]  CGLP_MODE_STOP  = 3'h1;
	localparam logic [2:0]  CGLP_MODE_IDLE  = 3'h3;
	localparam logic [2:0]  CGLP_STBY_RST   = 3'h3;
	localparam logic [2:0]  CGLP_GEAR_RST   = 3'h0;
	localparam logic [2:0]  CGLP_GEAR_MAX   = 3'h4;
	localparam logic [2:0]  CGLP_PRESC_RST  = 3'h0;
	localparam logic [11:0] CGLP_WUP_RST    = 12'h000;
	localparam logic [3:0]  CGLP_GEAR_DLY   = 4'h4;
	localparam int          CGLP_WUP_SHIFT  = 4;
	localparam int          CGLP_NPERIPH    = 4;
	localparam int          CGLP_NWAKE      = 3;

	typedef enum logic [1:0] {
		CGLP_NORMAL,
		CGLP_IDLE,
		CGLP_STOP,
		CGLP_WARM
	} cglp_mode_t;

	// Clock enables and clock selects toward the rest of the chip
	typedef struct packed {
		logic                    core_clk_en;
		logic [CGLP_NPERIPH-1:0] periph_clk_en;
		logic                    int_osc_run;
		logic                    ext_osc_run;
		logic                    pll_run;
		logic                    sys_src_ext;
		logic [2:0]              gear_sel;
		logic [2:0]              prescale_sel;
		logic                    periph_src_sel;
	} cglp_clk_t;

	// Pin control in every mode, including the low-power pin state
	typedef struct packed {
		logic osc_pin_takeover;
		logic gpio_io_en;
		logic x2_out;
		logic x2_oe;
		logic analog_keep;
	} cglp_pin_t;
endpackage

// file: cglp_warmup.sv
// Warm-up counter fed by a one-cycle tick of the chosen oscillator.
// Assumes the tick inputs are already synchronous to hclk.
`timescale 1ns/1ps
module cglp_warmup
	import cglp_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             start,
	input  wire logic             use_ext,
	input  wire logic             int_tick,
	input  wire logic             ext_tick,
	input  wire logic [11:0]      count_value,
	output logic                  busy
);
	// Elaboration refuses a counter too narrow for the shifted count
	if (CNT_W < 12 + CGLP_WUP_SHIFT) begin : g_width_check
		$error("cglp_warmup: CNT_W too small");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             busy;
	} cglp_wu_state_t;

	cglp_wu_state_t st_reg;
	cglp_wu_state_t st_next;
	logic           tick;

	always_comb begin
		st_next = st_reg;
		tick = use_ext ? ext_tick : int_tick; // RL2
		if (start) begin
			// Low four bits are dropped by the field, so restore them as zero
			st_next.cnt = CNT_W'({count_value, 4'h0});
			st_next.busy = 1'b1; // RL1
		end else if (st_reg.busy && tick) begin
			if (st_reg.cnt <= CNT_W'(1)) begin
				st_next.cnt = '0;
				st_next.busy = 1'b0; // RL1
			end else begin
				st_next.cnt = st_reg.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy = st_reg.busy;
endmodule

// file: cglp_ctrl_sva.sv
// Port checker for the clock gear and low-power controller.
// Assumes one hclk domain; bound into every cglp_ctrl.
`timescale 1ns/1ps
module cglp_ctrl_sva
	import cglp_pkg::*;
(
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  hsel,
	input wire logic [7:0]            haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic                  wait_req,
	input wire logic [CGLP_NWAKE-1:0] ext_wake_irq,
	input wire cglp_clk_t             clk_ctl,
	input wire cglp_pin_t             pin_ctl,
	input wire logic [1:0]            mode_state
);
	// ********
	// Data phase of a write to the system control word
	// ********
	logic sys_wr_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_wr_reg <= 1'b0;
		end else begin
			sys_wr_reg <= hsel && htrans[1] && hwrite && haddr == CGLP_SYS_OFF;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_normal_core: assert property (mode_state == CGLP_NORMAL |-> clk_ctl.core_clk_en)
		else $error("core clock off in normal mode");
	chk_idle_core: assert property (mode_state == CGLP_IDLE |-> !clk_ctl.core_clk_en)
		else $error("core clock on in idle");
	chk_stop_clocks: assert property (mode_state == CGLP_STOP |-> !clk_ctl.core_clk_en &&
		clk_ctl.periph_clk_en == '0 && !clk_ctl.int_osc_run && !clk_ctl.ext_osc_run && !clk_ctl.pll_run)
		else $error("clock left running in stop");
	chk_stop_pins: assert property (mode_state == CGLP_STOP |-> pin_ctl.x2_out && pin_ctl.analog_keep)
		else $error("stop pin state wrong");
	chk_gear_range: assert property (clk_ctl.gear_sel <= CGLP_GEAR_MAX)
		else $error("gear out of range");
	chk_gear_delay: assert property (sys_wr_reg |=> $stable(clk_ctl.gear_sel) [*3])
		else $error("gear changed too soon");
	chk_sleep_entry: assert property ((mode_state == CGLP_IDLE || mode_state == CGLP_STOP) &&
		$past(mode_state) == CGLP_NORMAL |-> $past(wait_req))
		else $error("low power without wait request");
	chk_stop_hold: assert property (mode_state == CGLP_STOP && ext_wake_irq == '0 |=>
		mode_state == CGLP_STOP) else $error("stop left without wake");
	chk_stop_exit: assert property (mode_state == CGLP_STOP |=>
		mode_state == CGLP_STOP || mode_state == CGLP_WARM) else $error("stop exit skips warm-up");
	chk_warm_gated: assert property (mode_state == CGLP_WARM |-> !clk_ctl.core_clk_en)
		else $error("core clocked during warm-up");
	cov_idle: cover property (mode_state == CGLP_IDLE);
	cov_stop_warm: cover property (mode_state == CGLP_STOP ##1 mode_state == CGLP_WARM);
	cov_gear: cover property ($changed(clk_ctl.gear_sel));
endmodule
bind cglp_ctrl cglp_ctrl_sva chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .wait_req(wait_req), .ext_wake_irq(ext_wake_irq),
	.clk_ctl(clk_ctl), .pin_ctl(pin_ctl), .mode_state(mode_state));

// file: cglp_core_model.sv
// Core, wake sources and oscillator ticks facing the controller.
// Assumes the bench pulses wait_cmd and wake_set for one cycle.
`timescale 1ns/1ps
module cglp_core_model
	import cglp_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        wait_cmd,
	input  wire logic [12:0] wake_set,
	input  wire logic [1:0]  mode_state,
	output logic             wait_req,
	output logic [12:0]      wake_lvl,
	output logic             int_osc_tick,
	output logic             ext_osc_tick
);
	logic [1:0] cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_req <= 1'b0;
			wake_lvl <= '0;
			cnt <= '0;
			int_osc_tick <= 1'b0;
			ext_osc_tick <= 1'b0;
		end else begin
			// Only wait-for-interrupt, never an event or deep sleep
			wait_req <= wait_cmd;
			// Levels hold until the core runs again
			wake_lvl <= (mode_state == CGLP_NORMAL) ? wake_set : (wake_lvl | wake_set);
			cnt <= cnt + 2'h1;
			// Oscillators are dead in stop, so no ticks there
			int_osc_tick <= cnt == 2'h0 && mode_state != CGLP_STOP;
			ext_osc_tick <= cnt[0] && mode_state != CGLP_STOP;
		end
	end
endmodule

// file: clock_gear_and_low_power_ctrl_test.sv
// Self-checking bench for the clock gear and low-power controller.
// Assumes the package, design, checker and core model compile first.
`timescale 1ns/1ps
module clock_gear_and_low_power_ctrl_test
	import cglp_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, wait_cmd, wait_req, hreadyout, hresp, it, et;
	logic [7:0]  haddr;
	logic [1:0]  htrans, mode_state;
	logic [31:0] hwdata, hrdata, rd, g_prev;
	logic [12:0] wake_set, wake_lvl;
	cglp_clk_t   clk_ctl;
	cglp_pin_t   pin_ctl;
	int          n_mismatch, comparisons, i;
	int          src[4] = '{12, 11, 3, 0};
	cglp_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .wait_req(wait_req), .ext_wake_irq(wake_lvl[2:0]),
		.idle_wake_irq(wake_lvl[10:3]), .watchdog_nmi(wake_lvl[11]), .systick_irq(wake_lvl[12]),
		.int_osc_tick(it), .ext_osc_tick(et), .clk_ctl(clk_ctl), .pin_ctl(pin_ctl),
		.mode_state(mode_state));
	cglp_core_model core_u (.hclk(hclk), .hresetn(hresetn), .wait_cmd(wait_cmd), .wake_set(wake_set),
		.mode_state(mode_state), .wait_req(wait_req), .wake_lvl(wake_lvl), .int_osc_tick(it),
		.ext_osc_tick(et));
	// ********
	// Tasks
	// ********
	task automatic complete_run();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// A wait that runs out ends the run as a failure
	task automatic wait_for(input logic [1:0] m, input logic bus_rdy);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge hclk);
			if (bus_rdy ? hreadyout === 1'b1 : mode_state === m) break;
		end
		if (n == 300) begin
			chk(32'h0, 32'h1);
			complete_run();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wait_for(2'h0, 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_for(2'h0, 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd & mask, exp);
	endtask
	task automatic pulse(input logic is_wait, input int b);
		wait_cmd <= is_wait;
		wake_set <= is_wait ? 13'h0000 : 13'(1 << b);
		@(posedge hclk);
		wait_cmd <= 1'b0;
		wake_set <= 13'h0000;
	endtask
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// ********
	// Main sequence
	// ********
	initial begin
		{hsel, hwrite, wait_cmd, haddr, htrans, hwdata, wake_set, n_mismatch, comparisons} = '0;
		hresetn = 1'b0;
		g_prev = 32'h0000_0000;
		cyc(12);
		hresetn <= 1'b1;
		cyc(1);
		chk(32'({clk_ctl.core_clk_en, clk_ctl.int_osc_run, clk_ctl.ext_osc_run, clk_ctl.pll_run,
			clk_ctl.sys_src_ext, mode_state}), 32'h0000_0060);
		rdc(CGLP_OSC_OFF, 32'h0002_0706, 32'h0000_0400);
		rdc(CGLP_SYS_OFF, 32'h0000_0707, 32'h0000_0000);
		rdc(CGLP_STBY_OFF, 32'h0000_0007, 32'h0000_0003);
		rdc(8'h20, 32'hffff_ffff, 32'h0000_0000);
		for (i = 4; i >= 0; i--) begin
			bus(1'b1, CGLP_SYS_OFF, 32'(i) | (32'(i) << 8));
			cyc(3);
			chk(32'(clk_ctl.gear_sel), g_prev);
			cyc(5);
			chk(32'({clk_ctl.gear_sel, clk_ctl.prescale_sel}), 32'(i * 9));
			g_prev = 32'(i);
		end
		bus(1'b1, CGLP_SYS_OFF, 32'h0000_0005);
		cyc(8);
		chk(32'(clk_ctl.gear_sel), 32'h0000_0000);
		bus(1'b1, CGLP_OSC_OFF, 32'h0010_8700);
		bus(1'b1, CGLP_OSC_OFF, 32'h0010_8701);
		cyc(2);
		rdc(CGLP_OSC_OFF, 32'h0000_0002, 32'h0000_0002);
		// Too few polls for the slower internal ticks to finish
		for (i = 0; i < 24; i++) begin
			bus(1'b0, CGLP_OSC_OFF, 32'h0000_0000);
			if (rd[1] === 1'b0) break;
		end
		chk(32'(i < 24), 32'h0000_0001);
		bus(1'b1, CGLP_OSC_OFF, 32'h0012_8700);
		rdc(CGLP_OSC_OFF, 32'h0002_0000, 32'h0002_0000);
		bus(1'b1, CGLP_OSC_OFF, 32'h0012_8200);
		cyc(2);
		chk(32'({clk_ctl.sys_src_ext, clk_ctl.int_osc_run, pin_ctl.osc_pin_takeover}), 32'h5);
		bus(1'b1, CGLP_SYS_OFF, 32'h0005_0000);
		bus(1'b1, CGLP_STBY_OFF, 32'h0000_0003);
		foreach (src[k]) begin
			pulse(1'b1, 0);
			wait_for(CGLP_IDLE, 1'b0);
			cyc(1);
			chk(32'({clk_ctl.core_clk_en, clk_ctl.periph_clk_en}), 32'h0000_0005);
			pulse(1'b0, src[k]);
			wait_for(CGLP_NORMAL, 1'b0);
		end
		bus(1'b1, CGLP_STBY_OFF, 32'h0000_0002);
		rdc(CGLP_STBY_OFF, 32'h0000_0007, 32'h0000_0003);
		bus(1'b1, CGLP_STBY_OFF, 32'h0000_0001);
		bus(1'b1, CGLP_WAKE_OFF, 32'h0000_0001);
		pulse(1'b1, 0);
		wait_for(CGLP_STOP, 1'b0);
		cyc(1);
		chk(32'({pin_ctl.gpio_io_en, pin_ctl.x2_out, clk_ctl.ext_osc_run}), 32'h2);
		pulse(1'b0, 12);
		pulse(1'b0, 1);
		cyc(10);
		chk(32'(mode_state), 32'(CGLP_STOP));
		pulse(1'b0, 0);
		wait_for(CGLP_WARM, 1'b0);
		wait_for(CGLP_NORMAL, 1'b0);
		bus(1'b1, CGLP_STBY_OFF, 32'h0001_0001);
		pulse(1'b1, 0);
		wait_for(CGLP_STOP, 1'b0);
		cyc(1);
		chk(32'(pin_ctl.gpio_io_en), 32'h0000_0001);
		hresetn <= 1'b0;
		cyc(2);
		hresetn <= 1'b1;
		cyc(20);
		chk(32'(mode_state), 32'(CGLP_NORMAL));
		rdc(CGLP_STBY_OFF, 32'h0001_0007, 32'h0000_0003);
		rdc(CGLP_OSC_OFF, 32'h0002_0102, 32'h0000_0000);
		complete_run();
	end
endmodule
